/* File: test/sso_plc_model.sv */
// Motion controller model that scans the status pins
`timescale 1ns/1ns
module sso_plc_model (
  input  wire logic       clk,
  input  wire logic [9:0] pins,
  output logic      [9:0] seen
);
  // Input card latches every pin once per scan, so the program sees each pin one clock late
  always_ff @(posedge clk) begin
    seen <= pins;
  end
endmodule // sso_plc_model

/* File: test/testbench.sv */
// Self-checking bench for the servo status outputs
`timescale 1ns/1ns
module testbench;
  localparam int Pu = 20;         // Short settle time keeps the run brief
  logic                clk, rst;  // Clock and reset
  sso_pkg::sso_cfg_t   cfg;       // Settings
  sso_pkg::sso_state_t st;        // Amplifier state
  logic                ff, rd, ip, sr, zs, wn, av;
  logic          [2:0] ac;        // Alarm code pins
  logic          [9:0] seen, e;   // Scanned image, oldest note
  logic          [9:0] q[$];      // Expected images
  logic                up, rch;   // Bench view of settle and reach
  int                  n_fail, cmp_count, seed, i;
  ////////////////////////////////////////////////////////////////////////////
  sso_status_out #(.PowerupCyc(Pu)) i_dut (.clk(clk), .rst(rst), .cfg(cfg), .st(st),
    .faultFreeOut(ff), .readyOut(rd), .inPositionOut(ip), .speedReachedOut(sr),
    .zeroSpeedOut(zs), .warningOut(wn), .alarmCodeOut(ac), .alarmCodeValid(av));
  sso_plc_model i_plc (.clk(clk), .pins({ff, rd, ip, sr, zs, wn, av, ac}), .seen(seen));
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 4 ns clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Compare one value and count it
  task automatic check(string nm, logic [9:0] s, logic [9:0] x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Step just past the edge
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected pin image; reach verdict holds when nothing decides it
  function automatic logic [9:0] model();
    logic [15:0] d;
    logic [23:0] a;
    logic  [3:0] s;
    logic        v;
    logic        f;
    d = st.motorSpeed > cfg.targetSpeed ? st.motorSpeed - cfg.targetSpeed : cfg.targetSpeed - st.motorSpeed;
    f = up & st.powerGood & ~st.baseShutoff & ~st.alarmActive;
    a = st.droop[23] ? -st.droop : st.droop;
    if (cfg.targetSpeed <= sso_pkg::LOW_SPEED_LIMIT) rch = 1;
    else if (!st.servoOn) rch = 0;
    else if (d <= sso_pkg::REACH_BAND) rch = 1;
    else if (!st.forwardStart && !st.reverseStart) rch = 0;
    s = {f & st.servoOn & st.ampPrepared, a <= cfg.inPosRange, rch, st.motorSpeed <= cfg.zeroSpeedThr};
    if (cfg.warnAssign) s[3 - cfg.warnSlot] = 1'b0;
    v = cfg.alarmCodeEn & st.alarmActive;
    if (v) s = 4'h0;
    return {f, s,
            up & st.powerGood & cfg.warnAssign & st.warningActive, v, v ? st.alarmCode : 3'h0};
  endfunction
  // Let inputs land, then note the expectation
  task automatic chk;
    tick(4);
    q.push_back(model());
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: code pins only matter while flagged valid
  always @(posedge clk) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      check("pins", e[3] ? seen : {seen[9:3], 3'h0}, e);
    end
  end
  // Watchdog, generous against about 200 cycles of tests
  initial begin
    #4000;
    n_fail++;
    wrap_up;
  end
  // Main sequence
  initial begin
    seed = 32'h460994b2;
    n_fail = 0;
    cmp_count = 0;
    up = 0;
    rch = 0;
    rst = 1;
    cfg = '{inPosRange: 24'h000064, targetSpeed: 16'h03e8, zeroSpeedThr: sso_pkg::ZERO_SPEED_DEF, default: '0};
    st = '0;
    st.servoOn = 1;
    st.ampPrepared = 1;
    tick(2);
    q.push_back(10'h000);
    rst = 0;
    st = '0;
    st.motorSpeed = 16'h0100;
    st.powerGood = 1;
    chk;
    tick(Pu);
    up = 1;
    chk;
    st.servoOn = 1;
    st.ampPrepared = 1;
    chk;
    st.ampPrepared = 0;
    chk;
    for (i = 0; i < 6; i++) begin
      st.droop = 24'($random(seed) % 200);
      st.motorSpeed = 16'($unsigned($random(seed)) % 100);
      chk;
    end
    st.droop = -24'sd100;
    st.motorSpeed = sso_pkg::ZERO_SPEED_DEF;
    chk;
    st.droop = 24'sd101;
    st.motorSpeed = 16'h0033;
    chk;
    st.motorSpeed = 16'h03f2;
    chk;
    st.motorSpeed = 16'h0200;
    st.forwardStart = 1;
    chk;
    st.forwardStart = 0;
    chk;
    st.motorSpeed = 16'h03de;
    chk;
    st.servoOn = 0;
    chk;
    cfg.targetSpeed = sso_pkg::LOW_SPEED_LIMIT;
    st = '{powerGood: 1, warningActive: 1, servoOn: 1, ampPrepared: 1, default: '0};
    chk;
    cfg.warnAssign = 1;
    for (i = 0; i < 4; i++) begin
      cfg.warnSlot = i[1:0];
      chk;
    end
    st.warningActive = 0;
    chk;
    cfg.alarmCodeEn = 1;
    for (i = 0; i < 3; i++) begin
      st.alarmActive = 1;
      st.alarmCode = 3'($random(seed));
      chk;
      st.alarmActive = 0;
      chk;
    end
    // Mid-run reset with pins high, then a fresh settle
    rst = 1;
    tick(4);
    q.push_back(10'h000);
    tick(1);
    rst = 0;
    up = 0;
    chk;
    tick(Pu);
    up = 1;
    chk;
    cfg.targetSpeed = 16'h03e8;
    st = '{powerGood: 1, baseShutoff: 1, motorSpeed: 16'h0200, droop: 24'sh1000, default: '0};
    chk;
    st.baseShutoff = 0;
    st.powerGood = 0;
    up = 0;
    chk;
    tick(3);
    wrap_up;
  end
endmodule // testbench

/* File: verilog/sso_pkg.sv */
// Package: constants and carrier types for the servo status output block
// Summary of operation
// - Fault-free drops on power loss or shutdown
// - Fault-free rises about one second after power
// - Ready only with servo on and amplifier prepared
// - In-position while droop within configured range
// - Wide range may hold in-position during slow turning
// - Speed-reached drops on servo off or idle starts
// - Speed-reached rises when speed nears target
// - Target at low-speed limit forces speed-reached
// - Zero-speed while speed at or below threshold
// - Warning needs pin assignment, displacing old signal
// - Warning output follows active warning condition
// - No warning: output low within one second
// - Alarm-code mode drives code during alarm
package sso_pkg;
  // Clock rate and power-up settle time
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned POWERUP_MS    = 1000;
  localparam int unsigned POWERUP_CYC   = CLK_HZ / 1000 * POWERUP_MS;
  // Speed in r/min, droop in pulses
  localparam int          SPEED_W       = 16;
  localparam int          DROOP_W       = 24;
  localparam int          CODE_W        = 3;
  localparam int          CNT_W         = 28;
  // Low-speed limit where speed-reached is forced on
  localparam logic [SPEED_W-1:0] LOW_SPEED_LIMIT = 16'h0014;
  // Reset value of the zero-speed threshold
  localparam logic [SPEED_W-1:0] ZERO_SPEED_DEF  = 16'h0032;
  // Speed-reached tolerance band around target
  localparam logic [SPEED_W-1:0] REACH_BAND      = 16'h000a;
  // Pin slot index the warning may displace
  localparam logic [1:0] SLOT_READY  = 2'h0;
  localparam logic [1:0] SLOT_INPOS  = 2'h1;
  localparam logic [1:0] SLOT_REACH  = 2'h2;
  localparam logic [1:0] SLOT_ZERO   = 2'h3;

  // Configuration inputs
  typedef struct packed {
    logic [DROOP_W-1:0] inPosRange;   // Droop window, pulses
    logic [SPEED_W-1:0] targetSpeed;  // Preset speed, r/min
    logic [SPEED_W-1:0] zeroSpeedThr; // Zero-speed threshold
    logic               warnAssign;   // Warning takes a pin
    logic [1:0]         warnSlot;     // Which pin it takes
    logic               alarmCodeEn;  // Alarm-code mode
  } sso_cfg_t;

  // Amplifier state inputs
  typedef struct packed {
    logic                powerGood;
    logic                baseShutoff;
    logic                alarmActive;
    logic [CODE_W-1:0]   alarmCode;
    logic                warningActive;
    logic                servoOn;
    logic                ampPrepared;
    logic                forwardStart;
    logic                reverseStart;
    logic signed [DROOP_W-1:0] droop;
    logic [SPEED_W-1:0]  motorSpeed;  // Magnitude, r/min
  } sso_state_t;

  // Registered pin image
  typedef struct packed {
    logic faultFree;
    logic ready;
    logic inPos;
    logic reached;
    logic zeroSpeed;
    logic warning;
  } sso_out_t;

  // Power-up phases, Gray coded
  typedef enum logic [1:0] {
    PU_OFF    = 2'b00,
    PU_SETTLE = 2'b01,
    PU_RUN    = 2'b11
  } sso_pu_t;
endpackage

/* File: verilog/sso_status_out.sv */
// Servo status output logic: fault-free, ready, in-position, speed, warning pins
`timescale 1ns/1ns
module sso_status_out #(
  parameter int unsigned PowerupCyc = sso_pkg::POWERUP_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire sso_pkg::sso_cfg_t        cfg,
  input  wire sso_pkg::sso_state_t      st,
  output logic                          faultFreeOut,
  output logic                          readyOut,
  output logic                          inPositionOut,
  output logic                          speedReachedOut,
  output logic                          zeroSpeedOut,
  output logic                          warningOut,
  output logic [sso_pkg::CODE_W-1:0]    alarmCodeOut,
  output logic                          alarmCodeValid
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Absolute value of signed droop
  // Most negative code folds onto 2^23, which is still right as unsigned
  // Shared by the pin logic and by the range checks below
  function automatic logic [sso_pkg::DROOP_W-1:0] absDroop(
    input logic signed [sso_pkg::DROOP_W-1:0] v);
    absDroop = v[sso_pkg::DROOP_W-1] ? (~v + 1'b1) : v;
  endfunction

  // Absolute distance between two speeds
  // Order-free, so overspeed and underspeed share one band
  function automatic logic [sso_pkg::SPEED_W-1:0] speedDist(
    input logic [sso_pkg::SPEED_W-1:0] a,
    input logic [sso_pkg::SPEED_W-1:0] b);
    speedDist = (a > b) ? (a - b) : (b - a);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequencing

  // Timer width covers a full second at the control clock
  sso_pkg::sso_pu_t             puState_q, puState_d;  // Phase
  logic [sso_pkg::CNT_W-1:0]    puCnt_q, puCnt_d;      // Settle timer
  logic                         puDone;                // Settle finished

  // Next phase; power loss always drops back to OFF
  always_comb begin
    puState_d = puState_q;
    puCnt_d   = puCnt_q;
    unique case (puState_q)
      sso_pkg::PU_OFF: begin
        // Timer held clear so every power-up waits the full time
        puCnt_d = '0;
        if (st.powerGood) begin
          puState_d = sso_pkg::PU_SETTLE;
        end
      end
      sso_pkg::PU_SETTLE: begin
        // A dip during settling restarts the wait from zero
        if (!st.powerGood) begin
          puState_d = sso_pkg::PU_OFF;
        end else if (puCnt_q >= sso_pkg::CNT_W'(PowerupCyc - 1)) begin
          puState_d = sso_pkg::PU_RUN;
        end else begin
          puCnt_d = puCnt_q + 1'b1;
        end
      end
      sso_pkg::PU_RUN: begin
        // Stay here until power is lost
        if (!st.powerGood) begin
          puState_d = sso_pkg::PU_OFF;
        end
      end
      default: begin
        // Unused code 2'b10 recovers to OFF
        puState_d = sso_pkg::PU_OFF;
      end
    endcase
  end

  // Register phase and timer
  // Synchronous reset parks the sequencer in OFF
  always_ff @(posedge clk) begin
    if (rst) begin
      puState_q <= sso_pkg::PU_OFF;
      puCnt_q   <= '0;
    end else begin
      puState_q <= puState_d;
      puCnt_q   <= puCnt_d;
    end
  end

  // Settled flag gates fault-free and warning
  assign puDone = (puState_q == sso_pkg::PU_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Status decisions

  // Pin image is registered so every pin comes from a flop
  sso_pkg::sso_out_t            pin_q, pin_d;          // Pin image
  logic [sso_pkg::CODE_W-1:0]   code_q, code_d;        // Alarm code
  logic                         codeVal_q, codeVal_d;  // Code shown
  logic                         reach_q, reach_d;      // Latched reached
  sso_pkg::sso_out_t            ord;                   // Ordinary signals
  logic                         runOk;                 // No fault, powered
  logic                         nearTarget;            // Within band

  // Speed-reached latch: set near target, clear on servo off or idle miss
  // Servo off beats a near-target hit; a low target beats both
  // Holds while a start input is on and speed is still away from target
  always_comb begin
    nearTarget = speedDist(st.motorSpeed, cfg.targetSpeed) <= sso_pkg::REACH_BAND;
    reach_d    = reach_q;
    if (cfg.targetSpeed <= sso_pkg::LOW_SPEED_LIMIT) begin
      reach_d = 1'b1;
    end else if (!st.servoOn) begin
      reach_d = 1'b0;
    end else if (nearTarget) begin
      reach_d = 1'b1;
    end else if (!st.forwardStart && !st.reverseStart) begin
      reach_d = 1'b0;
    end
  end

  // Ordinary signals, then warning remap and alarm-code override
  always_comb begin
    // Shutdown or missing power clears fault-free at once
    // Alarm counts as a protective shutdown here
    runOk         = puDone && st.powerGood && !st.baseShutoff && !st.alarmActive;
    ord.faultFree = runOk;
    ord.ready     = runOk && st.servoOn && st.ampPrepared;
    // Judged on droop only, so slow turning may keep it on
    ord.inPos     = absDroop(st.droop) <= cfg.inPosRange;
    ord.reached   = reach_q;
    ord.zeroSpeed = st.motorSpeed <= cfg.zeroSpeedThr;
    // Warning stays low until settled so power-up shows no false warning
    ord.warning   = puDone && st.powerGood && st.warningActive;
    // Start from the ordinary image, then apply overrides
    pin_d         = ord;
    code_d        = '0;
    codeVal_d     = 1'b0;
    if (cfg.warnAssign) begin
      // Assigned pin loses its previous signal
      unique case (cfg.warnSlot)
        sso_pkg::SLOT_READY: pin_d.ready     = 1'b0;
        sso_pkg::SLOT_INPOS: pin_d.inPos     = 1'b0;
        sso_pkg::SLOT_REACH: pin_d.reached   = 1'b0;
        sso_pkg::SLOT_ZERO:  pin_d.zeroSpeed = 1'b0;
      endcase
    end else begin
      pin_d.warning = 1'b0;
    end
    if (cfg.alarmCodeEn && st.alarmActive) begin
      // Code replaces ready, in-position, reached and zero-speed pins during alarm
      pin_d.ready     = 1'b0;
      pin_d.inPos     = 1'b0;
      pin_d.reached   = 1'b0;
      pin_d.zeroSpeed = 1'b0;
      code_d          = st.alarmCode;
      codeVal_d       = 1'b1;
    end
  end

  // Register all pins; reset holds them low
  // Code and its valid flag share the pin register timing
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q     <= '0;
      code_q    <= '0;
      codeVal_q <= 1'b0;
      reach_q   <= 1'b0;
    end else begin
      pin_q     <= pin_d;
      code_q    <= code_d;
      codeVal_q <= codeVal_d;
      reach_q   <= reach_d;
    end
  end

  // Outputs straight from the registers, no logic after the flops
  assign faultFreeOut    = pin_q.faultFree;
  assign readyOut        = pin_q.ready;
  assign inPositionOut   = pin_q.inPos;
  assign speedReachedOut = pin_q.reached;
  assign zeroSpeedOut    = pin_q.zeroSpeed;
  assign warningOut      = pin_q.warning;
  assign alarmCodeOut    = code_q;
  assign alarmCodeValid  = codeVal_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // All checks sleep during reset; the reset image has its own check

  fault_drop_a: assert property (@(posedge clk) disable iff (rst)
    (!st.powerGood || st.baseShutoff) |=> !faultFreeOut)
    else $error("fault-free stayed high on power loss or shutoff");

  powerup_wait_a: assert property (@(posedge clk) disable iff (rst)
    (puState_q == sso_pkg::PU_OFF) |=> !faultFreeOut)
    else $error("fault-free rose before settle time");

  ready_cond_a: assert property (@(posedge clk) disable iff (rst)
    readyOut |-> $past(st.servoOn && st.ampPrepared))
    else $error("ready high without servo on");

  inpos_range_a: assert property (@(posedge clk) disable iff (rst)
    (!cfg.alarmCodeEn && !cfg.warnAssign && absDroop(st.droop) <= cfg.inPosRange)
      |=> inPositionOut)
    else $error("in-position missing inside range");

  reach_off_a: assert property (@(posedge clk) disable iff (rst)
    (!st.servoOn && cfg.targetSpeed > sso_pkg::LOW_SPEED_LIMIT) |=> ##1 !speedReachedOut)
    else $error("speed-reached high after servo off");

  reach_low_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.targetSpeed <= sso_pkg::LOW_SPEED_LIMIT && !cfg.warnAssign && !cfg.alarmCodeEn)
      ##1 $stable(cfg) |=> speedReachedOut)
    else $error("speed-reached not forced at low target");

  zero_speed_a: assert property (@(posedge clk) disable iff (rst)
    zeroSpeedOut |-> $past(st.motorSpeed <= cfg.zeroSpeedThr))
    else $error("zero-speed high above threshold");

  warn_assign_a: assert property (@(posedge clk) disable iff (rst)
    !$past(cfg.warnAssign) |-> !warningOut)
    else $error("warning driven without pin assignment");

  code_override_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.alarmCodeEn && st.alarmActive) |=> (alarmCodeValid && !readyOut && alarmCodeOut == $past(st.alarmCode)))
    else $error("alarm code did not override ordinary pins");

  reset_low_a: assert property (@(posedge clk)
    rst |=> (pin_q == '0 && !alarmCodeValid))
    else $error("outputs not cleared by reset");

  // Fault-free must rise one cycle after all its conditions hold
  fault_rise_a: assert property (@(posedge clk) disable iff (rst)
    (puDone && st.powerGood && !st.baseShutoff && !st.alarmActive) |=> faultFreeOut)
    else $error("fault-free low with power settled and no fault");

  // Fault-free never leads the settle phase
  settle_time_a: assert property (@(posedge clk) disable iff (rst)
    faultFreeOut |-> $past(puDone))
    else $error("fault-free high before settle finished");

  // Timer never runs past its terminal count
  settle_bound_a: assert property (@(posedge clk) disable iff (rst)
    (puState_q == sso_pkg::PU_SETTLE) |-> (puCnt_q < sso_pkg::CNT_W'(PowerupCyc)))
    else $error("settle timer overran");

  // Power loss always drops the sequencer back to OFF
  power_off_a: assert property (@(posedge clk) disable iff (rst)
    !st.powerGood |=> (puState_q == sso_pkg::PU_OFF))
    else $error("sequencer kept running without power");

  // Ready must follow servo on once fault-free holds
  ready_high_a: assert property (@(posedge clk) disable iff (rst)
    (runOk && st.servoOn && st.ampPrepared && !cfg.warnAssign) |=> readyOut)
    else $error("ready low with servo on and amplifier prepared");

  // In-position only from a droop inside the window
  inpos_off_a: assert property (@(posedge clk) disable iff (rst)
    inPositionOut |-> $past(absDroop(st.droop) <= cfg.inPosRange))
    else $error("in-position high outside range");

  // Turning motor still shows in-position when droop is small
  slow_inpos_a: assert property (@(posedge clk) disable iff (rst)
    (st.motorSpeed != '0 && absDroop(st.droop) <= cfg.inPosRange && !cfg.warnAssign && !cfg.alarmCodeEn)
      |=> inPositionOut)
    else $error("in-position dropped while turning inside range");

  // Idle starts with speed away from target clear the latch
  reach_idle_a: assert property (@(posedge clk) disable iff (rst)
    (st.servoOn && !nearTarget && !st.forwardStart && !st.reverseStart &&
     cfg.targetSpeed > sso_pkg::LOW_SPEED_LIMIT) |=> ##1 !speedReachedOut)
    else $error("speed-reached high with idle starts off target");

  // Near target with servo on sets speed-reached two cycles on
  reach_near_a: assert property (@(posedge clk) disable iff (rst)
    (st.servoOn && nearTarget) ##1 (!cfg.warnAssign && !(cfg.alarmCodeEn && st.alarmActive))
      |=> speedReachedOut)
    else $error("speed-reached low near target");

  // Zero-speed must show at or below the threshold
  zero_speed_on_a: assert property (@(posedge clk) disable iff (rst)
    (st.motorSpeed <= cfg.zeroSpeedThr && !cfg.warnAssign && !(cfg.alarmCodeEn && st.alarmActive))
      |=> zeroSpeedOut)
    else $error("zero-speed low at or below threshold");

  // Active warning on an assigned pin shows once settled
  warn_follow_a: assert property (@(posedge clk) disable iff (rst)
    (puDone && st.powerGood && st.warningActive && cfg.warnAssign) |=> warningOut)
    else $error("warning low while warning active");

  // No warning, no warning pin
  warn_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !st.warningActive |=> !warningOut)
    else $error("warning high with no warning present");

  // Code pins go quiet once the alarm clears
  code_clear_a: assert property (@(posedge clk) disable iff (rst)
    !(cfg.alarmCodeEn && st.alarmActive) |=> (!alarmCodeValid && alarmCodeOut == '0))
    else $error("alarm code shown without alarm");

endmodule // sso_status_out
